// file: rtl/liu_cfg_pkg.sv
/*
 Per-channel transmit and jitter attenuator configuration bank: register
 indices, field positions, reset values, timing counts and carrier structs.
 Assumes a 10 MHz system clock and APB with 32-bit data.
*/
package liu_cfg_pkg;
	localparam int NUM_CH = 9;
	localparam int IDX_W = 11;
	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] CH_STRIDE = 11'h040;
	localparam logic [IDX_W-1:0] CH0_BASE = 11'h7c0;
	localparam logic [5:0] IDX_TX_JA = 6'h02;
	localparam logic [5:0] IDX_RX_JA = 6'h03;
	localparam logic [5:0] IDX_TX_DRV = 6'h04;
	localparam logic [5:0] IDX_TX_SYS = 6'h05;
	localparam logic [5:0] IDX_WAVE = 6'h06;
	// Attenuator fields (shared by both directions)
	localparam int JA_LIMIT_BIT = 4;
	localparam int JA_EN_BIT = 3;
	localparam int JA_DEPTH_LSB = 1;
	localparam int JA_BW_BIT = 0;
	// Line driver fields
	localparam int DRV_OE_BIT = 6;
	localparam int DRV_OFF_BIT = 5;
	localparam int DRV_HIZ_OC_BIT = 4;
	localparam int DRV_SING_BIT = 3;
	localparam int DRV_TERM_LSB = 0;
	// System interface fields
	localparam int SYS_MF_LSB = 5;
	localparam int SYS_EDGE_BIT = 4;
	localparam int SYS_INV_BIT = 3;
	localparam int SYS_CODE_BIT = 2;
	localparam int SYS_MODE_LSB = 0;
	// Waveform fields
	localparam int WAVE_SEL_LSB = 0;
	localparam int WAVE_ARB_BIT = 3;
	// Reset values and writable masks
	localparam logic [7:0] TX_JA_RST = 8'h00;
	localparam logic [7:0] RX_JA_RST = 8'h00;
	localparam logic [7:0] TX_DRV_RST = 8'h00;
	localparam logic [7:0] TX_SYS_RST = 8'h01;
	localparam logic [7:0] WAVE_RST = 8'h02;
	localparam logic [7:0] JA_MASK = 8'h1f;
	localparam logic [7:0] DRV_MASK = 8'h7f;
	localparam logic [7:0] SYS_MASK = 8'hff;
	localparam logic [7:0] WAVE_MASK = 8'h0f;
	// Encodings
	localparam logic [1:0] MODE_SR_NRZ = 2'h0;
	localparam logic [1:0] MODE_DR_RZ = 2'h2;
	localparam logic [2:0] TERM_EXTERNAL = 3'h7;
	localparam logic [7:0] DEPTH_128 = 8'h80;
	localparam logic [7:0] DEPTH_64 = 8'h40;
	localparam logic [7:0] DEPTH_32 = 8'h20;
	localparam logic [8:0] NEAR_MARGIN = 9'h002;
	// Over-current hold-off before high impedance
	localparam int OC_HIZ_TIME_US = 1000;
	localparam int CLK_FREQ_KHZ = 10000;
	localparam int OC_HIZ_CYCLES = OC_HIZ_TIME_US * CLK_FREQ_KHZ / 1000;
	localparam int OC_CNT_W = 16;

	typedef struct packed {
		logic pattern_det;
		logic pattern_on_tx;
		logic system_all_ones;
		logic tx_overcurrent;
		logic tx_loss_of_signal;
		logic system_excess_zeros;
		logic system_bipolar_violation;
		logic system_loss_of_signal;
	} tx_ind_t;

	typedef struct packed {
		logic [7:0] rx_fill;
		logic [7:0] tx_fill;
	} fifo_lvl_t;

	typedef struct packed {
		logic rx_atten_en;
		logic [7:0] rx_atten_depth;
		logic rx_atten_bandwidth;
		logic rx_speed_up;
		logic rx_slow_down;
		logic tx_atten_en;
		logic [7:0] tx_atten_depth;
		logic tx_atten_bandwidth;
		logic tx_speed_up;
		logic tx_slow_down;
		logic tx_power_down;
		logic line_tip_oe;
		logic line_ring_oe;
		logic current_limit;
		logic tx_single_ended;
		logic [2:0] term_sel;
		logic ext_match;
		logic tx_clock_edge_sel;
		logic tx_data_polarity;
		logic line_code;
		logic [1:0] tx_system_if_mode;
		logic [3:0] waveform_template_sel;
		logic arb_wave_en;
		logic tx_multifunc_pin;
	} chan_ctrl_t;
endpackage

// file: rtl/liu_tx_jitter_config_regs.sv
/*
 APB register bank with nine channel copies of the attenuator, line driver,
 system interface and waveform settings, and the per-channel control decode.
 Assumes synchronous status inputs and an APB master that holds requests.
*/
// Chosen here: the APB register port.
// Register map per channel block
// Index 2: transmit attenuator settings
// Index 3: receive attenuator settings
// Index 4: line driver settings
// Index 5: system interface settings
// Index 6: pulse template select
// Indices 0, 1 and 7..63 answer with an error
// Byte address is four times the index
// Channels one to eight sit at 0x40 index steps from zero
// Channel zero sits in its own block at index 0x7c0
// Anything above index 0x1ff outside that block is unmapped
//
// Bus behaviour
// Every access takes exactly one wait state
// Ready, error and read data are flops and stand one cycle
// Read data is zero outside the answering cycle
// Upper read data bits are always zero
// A write lands on the edge where ready is high
// A write with byte lane zero off completes and changes nothing
// Unmapped or misaligned writes change nothing
// Reserved bits are masked at the write and read back zero
// Trade-off: the wait state keeps the read path fully registered
//
// Reset
// External reset asserts at once and releases through two flops
// Every register returns to its documented default
// Control outputs read zero until the first edge after release
// Limitation: the bank is unusable for two edges after release
//
// Attenuator fields
// Bit 4 turns rate limiting on
// Bit 3 puts the attenuator in the path
// Bits 2..1 pick the FIFO depth
// Bit 0 picks the corner frequency
// Depth is handed over as a bit count, 128, 64 or 32
// Rate nudges need both the enable and limiting bits
// Speed up once fill plus margin reaches the depth
// Slow down once fill is at or below the margin
// Margin is two bits in both directions
// The transmit side reuses the receive encodings
// Hazard: fill levels are taken as already synchronous
//
// Line driver fields
// Bit 6 lets the driver leave high impedance
// Bit 5 powers the transmitter down
// Bit 4 allows the over-current trip to high impedance
// Bit 3 selects single-ended drive on the tip only
// Bits 2..0 pick the termination
// Power down always forces high impedance too
// Ring enable follows tip enable unless single-ended
// Current limiting is shown only while the tip drives
//
// Over-current timer
// One counter per channel counts edges of lasting over-current
// Any gap in the flag restarts the count
// The counter saturates so the trip cannot wrap away
// The trip drops the driver one edge after expiry
// With the trip bit clear the driver only limits current
// The count length is a parameter so tests can shorten it
// Limitation: the hold-off is counted in system clocks
//
// Termination
// Codes 0..3 are internal matching with a transformer
// Codes 4..6 are internal matching without one
// Code 7 flags external matching
// The analog side reads the raw code
//
// System interface fields
// Bits 7..5 pick the multifunction pin source
// Bit 4 picks the sampling edge
// Bit 3 inverts the data inputs
// Bit 2 picks the line code
// Bits 1..0 pick the interface mode
// The mode field resets to dual-rail NRZ
//
// Multifunction pin
// Active only in single-rail NRZ and dual-rail RZ
// Other modes hold the pin low
// Codes 0..4 work in both active modes
// Codes 5..7 work in dual-rail RZ only
// Reserved codes hold the pin low rather than float
// Code 0 needs the pattern detector on the transmit side
// The pin is a flop, one edge behind the status flags
//
// Waveform select
// Four bits pick a preset template
// Bit 3 hands over to the arbitrary waveform
// The field resets to the shortest T1 cable range
// The template table itself lives outside this bank
//
// Timing of control outputs
// Every control output comes straight from a flop
// A register write shows up one edge after it lands
// A status change shows up one edge after it is sampled
// Trade-off: one edge of latency buys glitch-free controls
//
// Scope
// No interrupt logic lives here
// No FIFO storage lives here
// No analog drive level control lives here
// Receive configuration other than the attenuator lives elsewhere
// Global registers in the 0x2xx and 0x3xx range live elsewhere
//
// Software notes
// Read back after write to confirm masked bits
// Enable the driver only after termination is set
// Set the attenuator depth before enabling it
// Changing depth while enabled may nudge the rate briefly
// Write the channel zero copy like any other channel
`timescale 1ns/100ps
`default_nettype none
module liu_tx_jitter_config_regs
	import liu_cfg_pkg::*;
#(
	parameter int OC_HIZ_CNT = OC_HIZ_CYCLES
)(
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [12:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire tx_ind_t [NUM_CH-1:0] ind_in,
	input wire fifo_lvl_t [NUM_CH-1:0] lvl_in,
	output wire chan_ctrl_t [NUM_CH-1:0] ctrl_out
);
	logic [1:0] rst_sync_r;
	logic rst_b;
	logic [7:0] tx_ja_r [NUM_CH];
	logic [7:0] rx_ja_r [NUM_CH];
	logic [7:0] tx_drv_r [NUM_CH];
	logic [7:0] tx_sys_r [NUM_CH];
	logic [7:0] wave_r [NUM_CH];
	chan_ctrl_t ctrl_r [NUM_CH];
	logic [IDX_W-1:0] idx;
	logic [3:0] ch;
	logic [5:0] slot;
	logic hit;
	logic [7:0] rd_byte;
	logic access;
	logic wr_commit;

	// Reset release through two flops
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			rst_sync_r <= 2'h0;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_b = rst_sync_r[1];

	// Address decode: channels 1..8 by stride, channel 0 in its own block
	always_comb
	begin
		idx = paddr_in[12:2];
		slot = idx[5:0];
		ch = 4'h0;
		hit = 1'b0;
		if (paddr_in[1:0] != 2'h0)
			hit = 1'b0;
		else if (idx[IDX_W-1:6] == CH0_BASE[IDX_W-1:6])
			hit = 1'b1;
		else if (idx[IDX_W-1:9] == 2'h0)
		begin
			ch = {1'b0, idx[8:6]} + 4'h1;
			hit = 1'b1;
		end
		if (!(slot >= IDX_TX_JA && slot <= IDX_WAVE))
			hit = 1'b0;
	end

	// Read mux over the selected copy
	always_comb
	begin
		rd_byte = 8'h00;
		if (!hit)
			rd_byte = 8'h00;
		else if (slot == IDX_TX_JA)
			rd_byte = tx_ja_r[ch];
		else if (slot == IDX_RX_JA)
			rd_byte = rx_ja_r[ch];
		else if (slot == IDX_TX_DRV)
			rd_byte = tx_drv_r[ch];
		else if (slot == IDX_TX_SYS)
			rd_byte = tx_sys_r[ch];
		else
			rd_byte = wave_r[ch];
	end

	// One wait state keeps every bus output registered
	assign access = psel_in & penable_in;
	assign wr_commit = access & pready_out & pwrite_in & hit & pstrb_in[0];

	always_ff @(posedge clk_in or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out <= 32'h0000_0000;
		end
		else
		begin
			pready_out <= access & ~pready_out;
			pslverr_out <= access & ~pready_out & ~hit;
			prdata_out <= (access & ~pready_out & ~pwrite_in) ? {24'h000000, rd_byte}
				: 32'h0000_0000;
		end
	end

	genvar c;
	generate
		for (c = 0; c < NUM_CH; c++)
		begin : g_ch
			logic wr_here;
			logic [OC_CNT_W-1:0] oc_cnt_r;
			logic oc_expired;
			logic [7:0] rx_depth;
			logic [7:0] tx_depth;
			logic [2:0] mf_sel;
			logic [1:0] mode;
			logic mf_nxt;
			chan_ctrl_t ctrl_nxt;

			assign wr_here = wr_commit && (ch == 4'(c));

			// Software-written copies; reserved bits stay zero
			always_ff @(posedge clk_in or negedge rst_b)
			begin
				if (!rst_b)
				begin
					tx_ja_r[c] <= TX_JA_RST;
					rx_ja_r[c] <= RX_JA_RST;
					tx_drv_r[c] <= TX_DRV_RST;
					tx_sys_r[c] <= TX_SYS_RST;
					wave_r[c] <= WAVE_RST;
				end
				else if (wr_here)
				begin
					if (slot == IDX_TX_JA)
						tx_ja_r[c] <= pwdata_in[7:0] & JA_MASK;
					else if (slot == IDX_RX_JA)
						rx_ja_r[c] <= pwdata_in[7:0] & JA_MASK;
					else if (slot == IDX_TX_DRV)
						tx_drv_r[c] <= pwdata_in[7:0] & DRV_MASK;
					else if (slot == IDX_TX_SYS)
						tx_sys_r[c] <= pwdata_in[7:0] & SYS_MASK;
					else
						wave_r[c] <= pwdata_in[7:0] & WAVE_MASK;
				end
			end

			// Over-current timer; saturates so the hold-off never wraps
			always_ff @(posedge clk_in or negedge rst_b)
			begin
				if (!rst_b)
					oc_cnt_r <= '0;
				else if (!ind_in[c].tx_overcurrent)
					oc_cnt_r <= '0;
				else if (!oc_expired)
					oc_cnt_r <= oc_cnt_r + 1'b1;
			end
			assign oc_expired = (oc_cnt_r >= OC_CNT_W'(OC_HIZ_CNT));

			// Depth decode; transmit shares the receive encoding
			assign rx_depth = rx_ja_r[c][JA_DEPTH_LSB+1] ? DEPTH_32
				: (rx_ja_r[c][JA_DEPTH_LSB] ? DEPTH_64 : DEPTH_128);
			assign tx_depth = tx_ja_r[c][JA_DEPTH_LSB+1] ? DEPTH_32
				: (tx_ja_r[c][JA_DEPTH_LSB] ? DEPTH_64 : DEPTH_128);
			assign mf_sel = tx_sys_r[c][SYS_MF_LSB +: 3];
			assign mode = tx_sys_r[c][SYS_MODE_LSB +: 2];

			// Multifunction pin source, gated by interface mode
			always_comb
			begin
				mf_nxt = 1'b0;
				if (mode == MODE_SR_NRZ || mode == MODE_DR_RZ)
				begin
					case (mf_sel)
						3'h0: mf_nxt = ind_in[c].pattern_on_tx & ind_in[c].pattern_det;
						3'h1: mf_nxt = ind_in[c].system_all_ones;
						3'h2: mf_nxt = ind_in[c].tx_overcurrent;
						3'h3: mf_nxt = ind_in[c].tx_loss_of_signal;
						3'h4: mf_nxt = ind_in[c].system_excess_zeros;
						3'h5: mf_nxt = (mode == MODE_DR_RZ)
							& ind_in[c].system_bipolar_violation;
						3'h6: mf_nxt = (mode == MODE_DR_RZ) & (ind_in[c].system_excess_zeros
							| ind_in[c].system_bipolar_violation);
						default: mf_nxt = (mode == MODE_DR_RZ)
							& ind_in[c].system_loss_of_signal;
					endcase
				end
			end

			// Control decode for the channel's datapath
			always_comb
			begin
				ctrl_nxt = '0;
				ctrl_nxt.rx_atten_en = rx_ja_r[c][JA_EN_BIT];
				ctrl_nxt.rx_atten_depth = rx_depth;
				ctrl_nxt.rx_atten_bandwidth = rx_ja_r[c][JA_BW_BIT];
				ctrl_nxt.rx_speed_up = rx_ja_r[c][JA_EN_BIT] & rx_ja_r[c][JA_LIMIT_BIT]
					& (({1'b0, lvl_in[c].rx_fill} + NEAR_MARGIN) >= {1'b0, rx_depth});
				ctrl_nxt.rx_slow_down = rx_ja_r[c][JA_EN_BIT] & rx_ja_r[c][JA_LIMIT_BIT]
					& ({1'b0, lvl_in[c].rx_fill} <= NEAR_MARGIN);
				ctrl_nxt.tx_atten_en = tx_ja_r[c][JA_EN_BIT];
				ctrl_nxt.tx_atten_depth = tx_depth;
				ctrl_nxt.tx_atten_bandwidth = tx_ja_r[c][JA_BW_BIT];
				ctrl_nxt.tx_speed_up = tx_ja_r[c][JA_EN_BIT] & tx_ja_r[c][JA_LIMIT_BIT]
					& (({1'b0, lvl_in[c].tx_fill} + NEAR_MARGIN) >= {1'b0, tx_depth});
				ctrl_nxt.tx_slow_down = tx_ja_r[c][JA_EN_BIT] & tx_ja_r[c][JA_LIMIT_BIT]
					& ({1'b0, lvl_in[c].tx_fill} <= NEAR_MARGIN);
				ctrl_nxt.tx_power_down = tx_drv_r[c][DRV_OFF_BIT];
				// Drive only when enabled, powered and not tripped
				ctrl_nxt.line_tip_oe = tx_drv_r[c][DRV_OE_BIT] & ~tx_drv_r[c][DRV_OFF_BIT]
					& ~(tx_drv_r[c][DRV_HIZ_OC_BIT] & oc_expired);
				ctrl_nxt.line_ring_oe = ctrl_nxt.line_tip_oe & ~tx_drv_r[c][DRV_SING_BIT];
				ctrl_nxt.current_limit = ind_in[c].tx_overcurrent & ctrl_nxt.line_tip_oe;
				ctrl_nxt.tx_single_ended = tx_drv_r[c][DRV_SING_BIT];
				ctrl_nxt.term_sel = tx_drv_r[c][DRV_TERM_LSB +: 3];
				ctrl_nxt.ext_match = (tx_drv_r[c][DRV_TERM_LSB +: 3] == TERM_EXTERNAL);
				ctrl_nxt.tx_clock_edge_sel = tx_sys_r[c][SYS_EDGE_BIT];
				ctrl_nxt.tx_data_polarity = tx_sys_r[c][SYS_INV_BIT];
				ctrl_nxt.line_code = tx_sys_r[c][SYS_CODE_BIT];
				ctrl_nxt.tx_system_if_mode = mode;
				ctrl_nxt.waveform_template_sel = wave_r[c][WAVE_SEL_LSB +: 4];
				ctrl_nxt.arb_wave_en = wave_r[c][WAVE_ARB_BIT];
				ctrl_nxt.tx_multifunc_pin = mf_nxt;
			end

			// Registered so every control output comes from a flop
			always_ff @(posedge clk_in or negedge rst_b)
			begin
				if (!rst_b)
					ctrl_r[c] <= '0;
				else
					ctrl_r[c] <= ctrl_nxt;
			end
			assign ctrl_out[c] = ctrl_r[c];
		end
	endgenerate
endmodule // liu_tx_jitter_config_regs
`default_nettype wire

// file: tb/liu_cfg_chk.sv
/* Port checker for the channel config bank.
 Assumes it is bound to the bank and sees only its ports. */
`timescale 1ns/100ps
`default_nettype none
module liu_cfg_chk
	import liu_cfg_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire chan_ctrl_t [NUM_CH-1:0] ctrl_out
);
	wire chan_ctrl_t c1 = ctrl_out[1];
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_b_in);
	// First access cycle, answer not yet given
	sequence acc_s;
		psel_in && penable_in && !pready_out;
	endsequence
	a_one_wait: assert property (acc_s |=> pready_out)
	else $error("ready late");
	a_ready_pulse: assert property (pready_out |=> !pready_out)
	else $error("ready held");
	a_err_ready: assert property (pslverr_out |-> pready_out)
	else $error("error without ready");
	a_rdata_idle: assert property (!pready_out |-> prdata_out == 32'h0)
	else $error("read data outside answer");
	a_ring_tip: assert property (c1.line_ring_oe |-> c1.line_tip_oe && !c1.tx_single_ended)
	else $error("ring driven alone");
	a_ext_match: assert property (c1.ext_match == (c1.term_sel == TERM_EXTERNAL))
	else $error("match decode");
	a_arb_wave: assert property (c1.arb_wave_en == c1.waveform_template_sel[3])
	else $error("arbitrary decode");
	a_limit_en: assert property (c1.tx_speed_up || c1.tx_slow_down |-> c1.tx_atten_en)
	else $error("rate nudge while off");
	a_off_hiz: assert property (c1.tx_power_down |-> !c1.line_tip_oe)
	else $error("driving while down");
endmodule // liu_cfg_chk
bind liu_tx_jitter_config_regs liu_cfg_chk chk_i (.clk_in, .rst_b_in, .psel_in, .penable_in,
	.prdata_out, .pready_out, .pslverr_out, .ctrl_out);
`default_nettype wire

// file: tb/liu_status_model.sv
/* Framer side model: status flags and FIFO levels for all channels.
 Assumes the bench sets one status word and one fill level. */
`timescale 1ns/100ps
`default_nettype none
module liu_status_model
	import liu_cfg_pkg::*;
(
	input wire logic clk_in,
	input wire tx_ind_t ind_req_in,
	input wire logic [7:0] fill_in,
	output var tx_ind_t [NUM_CH-1:0] ind_out,
	output var fifo_lvl_t [NUM_CH-1:0] lvl_out
);
	// Levels move only on the clock, as the framer's would
	always_ff @(posedge clk_in)
	begin
		for (int i = 0; i < NUM_CH; i++)
		begin
			ind_out[i] <= ind_req_in;
			lvl_out[i] <= {fill_in, fill_in};
		end
	end
endmodule // liu_status_model
`default_nettype wire

// file: tb/test_liu_tx_jitter_config_regs.sv
/* Bench for the config bank: APB master, random and corner cases.
 Assumes the bank, its package and the status model. */
`timescale 1ns/100ps
`default_nettype none
module test_liu_tx_jitter_config_regs
	import liu_cfg_pkg::*;
;
	localparam int OC_N = 20;
	logic clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic psel_in = 1'b0;
	logic penable_in = 1'b0;
	logic pwrite_in = 1'b0;
	logic [12:0] paddr_in = 13'h0;
	logic [31:0] pwdata_in = 32'h0;
	logic [3:0] pstrb_in = 4'hf;
	logic [31:0] prdata_out;
	logic pready_out, pslverr_out;
	tx_ind_t ind_req = '0;
	logic [7:0] fill = 8'h00;
	tx_ind_t [NUM_CH-1:0] ind_w;
	fifo_lvl_t [NUM_CH-1:0] lvl_w;
	chan_ctrl_t [NUM_CH-1:0] ctrl_out;
	wire chan_ctrl_t c1 = ctrl_out[1];
	int n_errors = 0;
	int checks_done = 0;
	int cyc = 0;
	int seed = 71390;
	logic [7:0] sh [NUM_CH][7];
	logic [7:0] rv [7] = '{8'h0, 8'h0, TX_JA_RST, RX_JA_RST, TX_DRV_RST, TX_SYS_RST, WAVE_RST};
	logic [7:0] mk [7] = '{8'h0, 8'h0, JA_MASK, JA_MASK, DRV_MASK, SYS_MASK, WAVE_MASK};
	logic [7:0] fl [4] = '{8'h3e, 8'h3d, 8'h02, 8'h03};

	liu_tx_jitter_config_regs #(.OC_HIZ_CNT(OC_N)) uut (.clk_in, .rst_b_in, .psel_in,
		.penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in, .prdata_out,
		.pready_out, .pslverr_out, .ind_in(ind_w), .lvl_in(lvl_w), .ctrl_out);
	liu_status_model sm (.clk_in, .ind_req_in(ind_req), .fill_in(fill), .ind_out(ind_w),
		.lvl_out(lvl_w));

	// 10 MHz clock
	always #50 clk_in = ~clk_in;

	task automatic report_and_stop;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Hang guard, far above the thousand or so cycles needed
	always @(posedge clk_in)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_errors++;
			report_and_stop();
		end
	end

	task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
		checks_done++;
		if (got !== ex)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
		end
	endtask

	function automatic logic [12:0] adr(input int ch, input logic [5:0] rg);
		logic [10:0] ix;
		ix = (ch == 0) ? CH0_BASE + 11'(rg) : 11'(ch - 1) * CH_STRIDE + 11'(rg);
		return {ix, 2'b00};
	endfunction

	function automatic logic [7:0] dep(input logic [1:0] c);
		return c[1] ? 8'h80 >> 2 : (c[0] ? 8'h40 : 8'h80);
	endfunction

	// Pin value from select, mode and status word
	function automatic logic mf(input logic [7:0] v, input tx_ind_t s);
		logic [7:0] p;
		p = {s.system_loss_of_signal, s.system_excess_zeros | s.system_bipolar_violation,
			s.system_bipolar_violation, s.system_excess_zeros, s.tx_loss_of_signal,
			s.tx_overcurrent, s.system_all_ones, s.pattern_det & s.pattern_on_tx};
		if (v[1:0] == 2'h2)
			return p[v[7:5]];
		return v[1:0] == 2'h0 && v[7:5] < 3'h5 && p[v[7:5]];
	endfunction

	// Request held until ready is seen at a rising edge
	task automatic apb(input logic w, input logic [12:0] a, input logic [7:0] d,
		output logic [7:0] r, output logic e);
		int t;
		t = 0;
		@(posedge clk_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= {24'h0, d};
		@(posedge clk_in);
		penable_in <= 1'b1;
		do @(posedge clk_in); while (pready_out !== 1'b1 && ++t < 50);
		r = prdata_out[7:0];
		e = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask

	task automatic wr(input int ch, input logic [5:0] rg, input logic [7:0] d);
		logic [7:0] r;
		logic e;
		apb(1'b1, adr(ch, rg), d, r, e);
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(posedge clk_in);
		@(negedge clk_in);
	endtask

	initial
	begin
		logic [7:0] r, v, s;
		logic e;
		int ch, rg;
		repeat (2) @(posedge clk_in);
		rst_b_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		foreach (sh[i, j])
			sh[i][j] = rv[j];
		repeat (80)
		begin
			ch = {$random(seed)} % NUM_CH;
			rg = 2 + {$random(seed)} % 5;
			v = 8'($random(seed));
			wr(ch, 6'(rg), v);
			sh[ch][rg] = v & mk[rg];
		end
		// Strobe off: write completes and changes nothing
		pstrb_in <= 4'h0;
		wr(3, IDX_WAVE, 8'h0b);
		pstrb_in <= 4'hf;
		for (ch = 0; ch < NUM_CH; ch++)
			for (rg = 2; rg < 7; rg++)
			begin
				apb(1'b0, adr(ch, 6'(rg)), 8'h00, r, e);
				chk("readback", sh[ch][rg], r);
			end
		apb(1'b0, adr(2, 6'h00), 8'h00, r, e);
		chk("unmapped", 8'h01, {7'h0, e});
		// Host power-saving write lands outside this bank and is refused
		apb(1'b1, 13'h0810, 8'h20, r, e);
		chk("power save write", 8'h01, {7'h0, e});
		for (int i = 0; i < 8; i++)
		begin
			v = 8'h08 | 8'(i);
			wr(1, IDX_RX_JA, v);
			wr(1, IDX_TX_JA, v & 8'h07);
			wait_n(1);
			chk("rx en", 8'h01, c1.rx_atten_en);
			chk("rx depth", dep(v[2:1]), c1.rx_atten_depth);
			chk("rx bw", v[0], c1.rx_atten_bandwidth);
			chk("tx en", 8'h00, c1.tx_atten_en);
			chk("tx depth", dep(v[2:1]), c1.tx_atten_depth);
		end
		// Depth 64, limiting on: edges of the two-bit margin
		wr(1, IDX_RX_JA, 8'h1a);
		wr(1, IDX_TX_JA, 8'h1a);
		for (int f = 0; f < 4; f++)
		begin
			@(posedge clk_in);
			fill <= fl[f];
			wait_n(2);
			chk("rx up", fl[f] >= 8'h3e, c1.rx_speed_up);
			chk("rx down", fl[f] <= 8'h02, c1.rx_slow_down);
			chk("tx up", fl[f] >= 8'h3e, c1.tx_speed_up);
			chk("tx down", fl[f] <= 8'h02, c1.tx_slow_down);
		end
		for (int i = 0; i < 8; i++)
		begin
			v = {1'b0, i[2], i[1], 1'b0, i[0], i[2:0]};
			wr(1, IDX_TX_DRV, v);
			wait_n(1);
			chk("tip", i[2] & ~i[1], c1.line_tip_oe);
			chk("ring", i[2] & ~i[1] & ~i[0], c1.line_ring_oe);
			chk("down", i[1], c1.tx_power_down);
			chk("ext", i == 7, c1.ext_match);
		end
		// Lasting over-current, with and without the high impedance bit
		wr(1, IDX_TX_DRV, 8'h50);
		@(posedge clk_in);
		ind_req.tx_overcurrent <= 1'b1;
		wait_n(3);
		chk("limit", 8'h01, c1.current_limit);
		wait_n(OC_N + 3);
		chk("oc hiz", 8'h00, c1.line_tip_oe);
		wr(1, IDX_TX_DRV, 8'h40);
		wait_n(OC_N + 3);
		chk("oc limit only", 8'h01, c1.line_tip_oe);
		for (int m = 0; m < 4; m++)
			for (int c = 0; c < 8; c++)
			begin
				v = 8'($random(seed));
				s = 8'($random(seed));
				v[7:5] = 3'(c);
				v[1:0] = 2'(m);
				@(posedge clk_in);
				ind_req <= s;
				wr(1, IDX_TX_SYS, v);
				wait_n(1);
				chk("mf pin", mf(v, s), c1.tx_multifunc_pin);
				chk("sys", v[4:0], {c1.tx_clock_edge_sel, c1.tx_data_polarity, c1.line_code,
					c1.tx_system_if_mode});
			end
		for (int w = 0; w < 16; w++)
		begin
			wr(1, IDX_WAVE, 8'(w));
			wait_n(1);
			chk("template", 8'(w), c1.waveform_template_sel);
			chk("arb", w > 7, c1.arb_wave_en);
		end
		report_and_stop();
	end
endmodule // test_liu_tx_jitter_config_regs
`default_nettype wire
